// file: hdl/self_program_flash_control_regs.svh
// Register offsets, bit positions and timing counts of the flash self-programming block
`ifndef SELF_PROGRAM_FLASH_CONTROL_REGS_SVH
`define SELF_PROGRAM_FLASH_CONTROL_REGS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_CONTROL_STATUS 5'h00
`define OFS_POINTER        5'h04
`define OFS_WRITE_DATA     5'h08
`define OFS_STORE_STROBE   5'h0c
`define OFS_LOAD_RESULT    5'h10

// ----------------------------------------------------------------
// Control/status bit positions and reset value
// ----------------------------------------------------------------
`define BIT_IRQ_ENABLE     7
`define BIT_SECTION_BUSY   6
`define BIT_RESERVED       5
`define BIT_SECTION_READ   4
`define BIT_LOCK_FUSE_READ 3
`define BIT_PAGE_PROGRAM   2
`define BIT_PAGE_ERASE     1
`define BIT_SELF_PROG_EN   0
`define CONTROL_RESET      8'h00

// ----------------------------------------------------------------
// Arming windows and pointer selectors
// ----------------------------------------------------------------
`define STORE_WINDOW_CYCLES 3'h4
`define LOAD_WINDOW_CYCLES  3'h3
`define SEL_LOW_FUSE        2'h0
`define SEL_LOCK_BITS       2'h1
`define SEL_EXT_FUSE        2'h2
`define SEL_HIGH_FUSE       2'h3
`define LOCK_UNUSED_BITS    6'h3f
`define ERASED_WORD         16'hffff

// ----------------------------------------------------------------
// Programming time
// ----------------------------------------------------------------
`define CLK_MHZ        100
`define PROG_MIN_US    3700
`define PROG_MAX_US    4500
`define RC_TICK_US     1
`define RC_TICK_CYCLES (`CLK_MHZ * `RC_TICK_US)
`define PROG_TICKS     ((`PROG_MIN_US + `RC_TICK_US - 1) / `RC_TICK_US)

`endif

// file: hdl/self_program_flash_control_pkg.sv
// Types shared by the flash self-programming block
package self_program_flash_control_pkg;

  typedef enum logic [4:0] {
    CMD_BUFFER_LOAD    = 5'h01,
    CMD_PAGE_ERASE     = 5'h03,
    CMD_PAGE_PROGRAM   = 5'h05,
    CMD_LOCK_FUSE_READ = 5'h09,
    CMD_SECTION_READ   = 5'h11
  } command_e;

  typedef enum logic [1:0] {
    OP_IDLE    = 2'b00,
    OP_ERASE   = 2'b01,
    OP_PROGRAM = 2'b10
  } op_state_e;

endpackage

// file: hdl/page_buffer_ram.sv
// Temporary page buffer memory with registered read port
`timescale 1ns/10ps
module page_buffer_ram #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  // Clock
  input  wire logic                     clock,
  // Write port
  input  wire logic                     wr_en,
  input  wire logic [$clog2(DEPTH)-1:0] wr_index,
  input  wire logic [WIDTH-1:0]         wr_data,
  // Read port
  input  wire logic [$clog2(DEPTH)-1:0] rd_index,
  output logic      [WIDTH-1:0]         rd_data
);

  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clock)
  begin
    if (wr_en)
    begin
      mem[wr_index] <= wr_data;
    end
    rd_data <= mem[rd_index];
  end

endmodule

// file: hdl/flash_op_timer.sv
// Timed erase/program sequencer paced by the RC tick divider
`timescale 1ns/10ps
`include "self_program_flash_control_regs.svh"
module flash_op_timer
  import self_program_flash_control_pkg::*;
#(
  parameter int DIV       = `RC_TICK_CYCLES,
  parameter int TICKS     = `PROG_TICKS,
  parameter int PAGE_BITS = 10
) (
  // Clock and power-on reset
  input  wire logic                 clock,
  input  wire logic                 por_n,
  // Request
  input  wire logic                 start,
  input  wire logic                 erase,
  input  wire logic [PAGE_BITS-1:0] page,
  // Status
  output logic                      busy,
  output logic                      done,
  output logic                      erase_active,
  output logic      [PAGE_BITS-1:0] op_page
);

  localparam int DW = $clog2(DIV + 1);
  localparam int TW = $clog2(TICKS + 1);

  typedef struct packed {
    op_state_e            state;
    logic [DW-1:0]        div;
    logic [TW-1:0]        ticks;
    logic [PAGE_BITS-1:0] page;
  } timer_s;

  timer_s timer_reg;
  timer_s timer_next;
  logic   tick;
  logic   last;

  assign tick         = (timer_reg.div == DW'(DIV - 1));
  assign last         = tick && (timer_reg.ticks == TW'(TICKS - 1));
  assign busy         = (timer_reg.state != OP_IDLE);
  assign done         = busy && last;
  assign erase_active = (timer_reg.state == OP_ERASE);
  assign op_page      = timer_reg.page;

  always_comb
  begin
    timer_next = timer_reg;
    unique case (timer_reg.state)
      OP_IDLE:
      begin
        if (start)
        begin
          timer_next.state = erase ? OP_ERASE : OP_PROGRAM;
          timer_next.page  = page;
          timer_next.div   = '0;
          timer_next.ticks = '0;
        end
      end
      OP_ERASE, OP_PROGRAM:
      begin
        // One RC tick per divider wrap
        if (tick)
        begin
          timer_next.div   = '0;
          timer_next.ticks = timer_reg.ticks + 1'b1; // see RULE22
        end
        else
        begin
          timer_next.div = timer_reg.div + 1'b1;
        end
        if (last)
        begin
          timer_next.state = OP_IDLE;
        end
      end
      default:
      begin
        timer_next.state = OP_IDLE;
      end
    endcase
  end

  // Only power-on clears it, so a system reset cannot cut a write short
  always_ff @(posedge clock or negedge por_n)
  begin
    if (!por_n)
    begin
      timer_reg <= '0; // see RULE21
    end
    else
    begin
      timer_reg <= timer_next;
    end
  end

endmodule

// file: hdl/self_program_flash_control.sv
// Flash self-programming control: command register, page buffer and timed operations
// Function
// RULE1 - Pointer high bits page, low bits word
// RULE2 - Load uses pointer bit 0 as byte select
// RULE3 - Ready interrupt while enable bit is clear
// RULE4 - Section busy flag always reads zero
// RULE5 - Bit five reserved, reads zero
// RULE6 - Section read command clears the page buffer
// RULE7 - Armed load returns lock or fuse bits
// RULE8 - Armed store programs buffer into page, halts
// RULE9 - Program bit clears on completion or timeout
// RULE10 - Armed store erases page, halts, then clears
// RULE11 - Enable bit opens store for four cycles
// RULE12 - Plain store loads data word into buffer
// RULE13 - Enable clears after store; held during operations
// RULE14 - Only five command codes take effect
// RULE15 - EEPROM write blocks programming and fuse reads
// RULE16 - Software checks EEPROM busy before commands
// RULE17 - Lock bits return in result bits 1:0
// RULE18 - Lock/fuse arm clears after load or timeout
// RULE19 - Pointer selects low, high or extended fuse
// RULE20 - Programmed cells read zero, unprogrammed one
// RULE21 - Reset does not abort a running write
// RULE22 - Operations timed by RC tick, within limits
// RULE23 - Buffer erased after program, section read, reset
// RULE24 - EEPROM write during buffer fill loses data
// RULE25 - Page/word split set by page size parameter
`timescale 1ns/10ps
`include "self_program_flash_control_regs.svh"
module self_program_flash_control
  import self_program_flash_control_pkg::*;
#(
  parameter int    PAGE_WORDS = 32,
  parameter int    RC_DIV     = `RC_TICK_CYCLES,
  parameter int    PROG_TICKS = `PROG_TICKS,
  localparam int   WORD_BITS  = $clog2(PAGE_WORDS),
  localparam int   PAGE_BITS  = 15 - WORD_BITS
) (
  // Clock and resets
  input  wire logic                 clock,
  input  wire logic                 rstn,
  input  wire logic                 por_n,
  // Avalon-MM register slave
  input  wire logic [4:0]           avs_address,
  input  wire logic                 avs_read,
  input  wire logic                 avs_write,
  input  wire logic [31:0]          avs_writedata,
  input  wire logic [3:0]           avs_byteenable,
  output logic      [31:0]          avs_readdata,
  output logic                      avs_waitrequest,
  // Core status
  input  wire logic                 global_irq_flag,
  input  wire logic                 eeprom_write_busy,
  output logic                      program_ready_irq,
  output logic                      cpu_halt,
  // Nonvolatile cells, one means programmed
  input  wire logic [1:0]           lock_programmed,
  input  wire logic [7:0]           low_fuse_programmed,
  input  wire logic [7:0]           high_fuse_programmed,
  input  wire logic [7:0]           extended_fuse_programmed,
  // Flash array
  output logic      [14:0]          flash_rd_addr,
  input  wire logic [15:0]          flash_rd_data,
  output logic                      flash_op_busy,
  output logic                      flash_op_erase,
  output logic      [PAGE_BITS-1:0] flash_op_page,
  input  wire logic [WORD_BITS-1:0] buffer_rd_index,
  output logic      [15:0]          buffer_rd_data
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                  irq_en;
    logic                  sect_re;
    logic                  lf_arm;
    logic                  pg_wr;
    logic                  pg_er;
    logic                  spm_en;
    logic [2:0]            win;
    logic [15:0]           ptr;
    logic [15:0]           wdata;
    logic [PAGE_WORDS-1:0] valid;
    logic                  rd_done;
    logic [31:0]           rdata;
    logic                  halt;
    logic                  ack;
    logic                  ee_d;
    logic                  irq;
    logic                  buf_ok;
  } ctrl_s;

  ctrl_s                 state_reg;
  ctrl_s                 state_next;
  logic                  wr_ctl;
  logic                  wr_ptr;
  logic                  wr_data;
  logic                  wr_store;
  logic                  rd_load;
  logic [4:0]            cmd;
  logic                  cmd_legal;
  logic                  spm_open;
  logic                  lpm_open;
  logic                  start_op;
  logic [WORD_BITS-1:0]  word_idx;
  logic [7:0]            fuse_byte;
  logic [7:0]            load_byte;
  logic                  buf_we;
  logic [15:0]           buf_q;
  logic                  op_busy;
  logic                  op_done;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  assign wr_ctl   = avs_write && (avs_address == `OFS_CONTROL_STATUS) && avs_byteenable[0];
  assign wr_ptr   = avs_write && (avs_address == `OFS_POINTER);
  assign wr_data  = avs_write && (avs_address == `OFS_WRITE_DATA);
  assign wr_store = avs_write && (avs_address == `OFS_STORE_STROBE);
  assign rd_load  = avs_read && (avs_address == `OFS_LOAD_RESULT);
  assign cmd      = avs_writedata[4:0];
  assign cmd_legal = cmd inside {CMD_BUFFER_LOAD, CMD_PAGE_ERASE, CMD_PAGE_PROGRAM,
                                 CMD_LOCK_FUSE_READ, CMD_SECTION_READ}; // see RULE14

  assign word_idx = state_reg.ptr[WORD_BITS:1]; // see RULE1 see RULE25

  // Store accepted only inside the window and outside EEPROM writes
  assign spm_open = state_reg.spm_en && (state_reg.win < `STORE_WINDOW_CYCLES)
                    && !eeprom_write_busy; // see RULE11 see RULE15
  assign lpm_open = state_reg.spm_en && state_reg.lf_arm
                    && (state_reg.win < `LOAD_WINDOW_CYCLES)
                    && !eeprom_write_busy; // see RULE7 see RULE15
  assign start_op = wr_store && !state_reg.ack && !op_busy && spm_open
                    && (state_reg.pg_wr || state_reg.pg_er); // see RULE8 see RULE10

  // ----------------------------------------------------------------
  // Load result
  // ----------------------------------------------------------------
  always_comb
  begin
    unique case (state_reg.ptr[1:0])
      `SEL_LOW_FUSE:  fuse_byte = ~low_fuse_programmed; // see RULE19 see RULE20
      `SEL_LOCK_BITS: fuse_byte = {`LOCK_UNUSED_BITS, ~lock_programmed}; // see RULE17
      `SEL_EXT_FUSE:  fuse_byte = ~extended_fuse_programmed; // see RULE19
      `SEL_HIGH_FUSE: fuse_byte = ~high_fuse_programmed; // see RULE19
    endcase
  end

  assign load_byte = lpm_open ? fuse_byte
                   : (state_reg.ptr[0] ? flash_rd_data[15:8]
                                       : flash_rd_data[7:0]); // see RULE2 see RULE7

  // ----------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------
  // Reads take one wait cycle so read data come from a flop;
  // a timed store is held off until the operation is done.
  always_comb
  begin
    if (avs_read)
    begin
      avs_waitrequest = !state_reg.rd_done;
    end
    else if (wr_store && !state_reg.ack)
    begin
      avs_waitrequest = op_busy || start_op; // see RULE8 see RULE10
    end
    else
    begin
      avs_waitrequest = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    state_next        = state_reg;
    buf_we            = 1'b0;
    state_next.ee_d   = eeprom_write_busy;
    state_next.buf_ok = state_reg.valid[buffer_rd_index];
    state_next.irq    = state_reg.irq_en && global_irq_flag
                        && !state_reg.spm_en; // see RULE3

    if (state_reg.spm_en && (state_reg.win != 3'h7))
    begin
      state_next.win = state_reg.win + 3'h1;
    end

    // Arming windows run out
    if (state_reg.spm_en && !state_reg.halt)
    begin
      if (state_reg.lf_arm && (state_reg.win == `LOAD_WINDOW_CYCLES - 3'h1))
      begin
        state_next.lf_arm = 1'b0; // see RULE18
        state_next.spm_en = 1'b0;
      end
      if (state_reg.win == `STORE_WINDOW_CYCLES - 3'h1)
      begin
        state_next.sect_re = 1'b0; // see RULE9 see RULE10 see RULE13
        state_next.lf_arm  = 1'b0;
        state_next.pg_wr   = 1'b0;
        state_next.pg_er   = 1'b0;
        state_next.spm_en  = 1'b0;
      end
    end

    if (eeprom_write_busy && !state_reg.ee_d)
    begin
      state_next.valid = '0; // see RULE24
    end

    // Control write: interrupt enable unless halted, command bits only when legal
    if (wr_ctl && !state_reg.halt)
    begin
      state_next.irq_en = avs_writedata[`BIT_IRQ_ENABLE];
      if (cmd_legal && !eeprom_write_busy && !op_busy) // see RULE14 see RULE15
      begin
        state_next.sect_re = cmd[`BIT_SECTION_READ];
        state_next.lf_arm  = cmd[`BIT_LOCK_FUSE_READ];
        state_next.pg_wr   = cmd[`BIT_PAGE_PROGRAM];
        state_next.pg_er   = cmd[`BIT_PAGE_ERASE];
        state_next.spm_en  = cmd[`BIT_SELF_PROG_EN]; // see RULE11
        state_next.win     = 3'h0;
        if (cmd == CMD_SECTION_READ)
        begin
          state_next.valid = '0; // see RULE6 see RULE23
        end
      end
    end

    if (wr_ptr)
    begin
      if (avs_byteenable[0])
      begin
        state_next.ptr[7:0] = avs_writedata[7:0];
      end
      if (avs_byteenable[1])
      begin
        state_next.ptr[15:8] = avs_writedata[15:8];
      end
    end

    if (wr_data)
    begin
      if (avs_byteenable[0])
      begin
        state_next.wdata[7:0] = avs_writedata[7:0];
      end
      if (avs_byteenable[1])
      begin
        state_next.wdata[15:8] = avs_writedata[15:8];
      end
    end

    // Store strobe
    if (wr_store && state_reg.ack)
    begin
      state_next.ack = 1'b0;
    end
    else if (start_op)
    begin
      state_next.halt = 1'b1; // see RULE8 see RULE10
    end
    else if (wr_store && !op_busy && state_reg.spm_en)
    begin
      // A buffer word takes one load only until the buffer is erased
      if (spm_open && !state_reg.sect_re && !state_reg.lf_arm
          && !state_reg.valid[word_idx])
      begin
        buf_we                     = 1'b1; // see RULE12 see RULE23
        state_next.valid[word_idx] = 1'b1;
      end
      state_next.sect_re = 1'b0; // see RULE13
      state_next.lf_arm  = 1'b0;
      state_next.pg_wr   = 1'b0;
      state_next.pg_er   = 1'b0;
      state_next.spm_en  = 1'b0;
    end

    // Timed operation finished
    if (op_done)
    begin
      if (state_reg.halt)
      begin
        state_next.ack  = 1'b1;
        state_next.halt = 1'b0;
      end
      state_next.pg_wr  = 1'b0; // see RULE9 see RULE10 see RULE13
      state_next.pg_er  = 1'b0;
      state_next.spm_en = 1'b0;
      if (!flash_op_erase)
      begin
        state_next.valid = '0; // see RULE23
      end
    end

    // Register reads, answered from a flop one cycle later
    if (avs_read && !state_reg.rd_done)
    begin
      state_next.rd_done = 1'b1;
      state_next.rdata   = '0;
      unique case (avs_address)
        `OFS_CONTROL_STATUS:
        begin
          state_next.rdata[`BIT_IRQ_ENABLE]     = state_reg.irq_en;
          state_next.rdata[`BIT_SECTION_BUSY]   = 1'b0; // see RULE4
          state_next.rdata[`BIT_RESERVED]       = 1'b0; // see RULE5
          state_next.rdata[`BIT_SECTION_READ]   = state_reg.sect_re;
          state_next.rdata[`BIT_LOCK_FUSE_READ] = state_reg.lf_arm;
          state_next.rdata[`BIT_PAGE_PROGRAM]   = state_reg.pg_wr;
          state_next.rdata[`BIT_PAGE_ERASE]     = state_reg.pg_er;
          state_next.rdata[`BIT_SELF_PROG_EN]   = state_reg.spm_en;
        end
        `OFS_POINTER:     state_next.rdata[15:0] = state_reg.ptr;
        `OFS_WRITE_DATA:  state_next.rdata[15:0] = state_reg.wdata;
        `OFS_LOAD_RESULT: state_next.rdata[7:0]  = load_byte;
        default:          state_next.rdata       = '0;
      endcase
      if (rd_load && lpm_open)
      begin
        state_next.lf_arm = 1'b0; // see RULE18
        state_next.spm_en = 1'b0;
      end
    end
    else
    begin
      state_next.rd_done = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      state_reg <= '0; // see RULE23
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // Page buffer and timed operation
  // ----------------------------------------------------------------
  page_buffer_ram #(
    .WIDTH (16),
    .DEPTH (PAGE_WORDS)
  ) buffer_ram (
    .clock    (clock),
    .wr_en    (buf_we),
    .wr_index (word_idx),
    .wr_data  (state_reg.wdata),
    .rd_index (buffer_rd_index),
    .rd_data  (buf_q)
  );

  flash_op_timer #(
    .DIV       (RC_DIV),
    .TICKS     (PROG_TICKS),
    .PAGE_BITS (PAGE_BITS)
  ) op_timer (
    .clock        (clock),
    .por_n        (por_n),
    .start        (start_op),
    .erase        (state_reg.pg_er),
    .page         (state_reg.ptr[15:WORD_BITS+1]), // see RULE1 see RULE8 see RULE10
    .busy         (op_busy),
    .done         (op_done),
    .erase_active (flash_op_erase),
    .op_page      (flash_op_page)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Unloaded words go to the array as erased data
  assign buffer_rd_data    = state_reg.buf_ok ? buf_q : `ERASED_WORD;
  assign avs_readdata      = state_reg.rdata;
  assign program_ready_irq = state_reg.irq;
  assign cpu_halt          = state_reg.halt || op_busy;
  assign flash_op_busy     = op_busy;
  assign flash_rd_addr     = state_reg.ptr[15:1];

endmodule

// file: tb/self_program_flash_control_props.sv
// Checker on the block's ports
`timescale 1ns/10ps
module self_program_flash_control_props #(
  parameter int  PAGE_WORDS = 32,
  parameter int  RC_DIV     = 100,
  parameter int  PROG_TICKS = 3700,
  localparam int PAGE_BITS  = 15 - $clog2(PAGE_WORDS)
) (
  // Clock and reset
  input wire logic                 clock,
  input wire logic                 rstn,
  // Register bus
  input wire logic [4:0]           avs_address,
  input wire logic                 avs_read,
  input wire logic                 avs_write,
  input wire logic [31:0]          avs_readdata,
  input wire logic                 avs_waitrequest,
  // Core status
  input wire logic                 global_irq_flag,
  input wire logic                 eeprom_write_busy,
  input wire logic                 program_ready_irq,
  input wire logic                 cpu_halt,
  // Flash operation
  input wire logic                 flash_op_busy,
  input wire logic                 flash_op_erase,
  input wire logic [PAGE_BITS-1:0] flash_op_page
);
  localparam int OP = RC_DIV * PROG_TICKS;
  int run;
  // No reset: counts across a system reset
  always_ff @(posedge clock)
    run <= flash_op_busy ? run + 1 : 0;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);
  a_halt_tracks_op: assert property (cpu_halt == flash_op_busy)
    else $error("halt mismatch");
  a_op_duration: assert property ($fell(flash_op_busy) |-> run >= OP && run <= OP + 2)
    else $error("bad op length");
  a_op_args_held: assert property (flash_op_busy && $past(flash_op_busy) |->
    $stable(flash_op_page) && $stable(flash_op_erase))
    else $error("op args changed");
  a_busy_bit_zero: assert property (avs_read && !avs_waitrequest && avs_address == 5'h00 |->
    !avs_readdata[6]) else $error("busy bit set");
  a_resv_bit_zero: assert property (avs_read && !avs_waitrequest && avs_address == 5'h00 |->
    !avs_readdata[5]) else $error("reserved bit set");
  a_store_stalls: assert property (avs_write && avs_address == 5'h0c && flash_op_busy |->
    avs_waitrequest) else $error("store not stalled");
  a_eeprom_blocks: assert property (eeprom_write_busy |=> !$rose(flash_op_busy))
    else $error("op during eeprom write");
  a_irq_gated: assert property (program_ready_irq |-> $past(global_irq_flag))
    else $error("irq without global flag");
  cover property ($rose(flash_op_busy) && flash_op_erase);
  cover property ($rose(flash_op_busy) && !flash_op_erase);
  cover property (avs_read && !avs_waitrequest && avs_address == 5'h10);
endmodule
bind self_program_flash_control self_program_flash_control_props #(.PAGE_WORDS(PAGE_WORDS),
  .RC_DIV(RC_DIV), .PROG_TICKS(PROG_TICKS)) i_props (.clock, .rstn, .avs_address,
  .avs_read, .avs_write, .avs_readdata, .avs_waitrequest, .global_irq_flag,
  .eeprom_write_busy, .program_ready_irq, .cpu_halt, .flash_op_busy, .flash_op_erase,
  .flash_op_page);

// file: tb/flash_array_model.sv
// Flash array model, erased to all ones
`timescale 1ns/10ps
module flash_array_model #(
  parameter int WORD_BITS = 2,
  parameter int PAGE_BITS = 13
) (
  // Clock
  input  wire logic                 clock,
  // Block side
  input  wire logic [14:0]          flash_rd_addr,
  output logic      [15:0]          flash_rd_data,
  input  wire logic                 flash_op_busy,
  input  wire logic                 flash_op_erase,
  input  wire logic [PAGE_BITS-1:0] flash_op_page,
  output logic      [WORD_BITS-1:0] buffer_rd_index,
  input  wire logic [15:0]          buffer_rd_data
);
  logic [15:0]          mem [0:63];
  logic [WORD_BITS-1:0] idx_q;
  initial
  begin
    foreach (mem[i]) mem[i] = 16'hffff;
    buffer_rd_index = '0;
  end
  // Higher pages alias onto these sixteen
  assign flash_rd_data = mem[flash_rd_addr[5:0]];
  // Buffer data lags its index by a cycle
  always @(posedge clock)
  begin
    idx_q <= buffer_rd_index;
    if (flash_op_busy)
    begin
      buffer_rd_index <= buffer_rd_index + 1'b1;
      mem[{flash_op_page[5-WORD_BITS:0], idx_q}] <= flash_op_erase ? 16'hffff : buffer_rd_data;
    end
  end
endmodule

// file: tb/self_program_flash_control_tb_top.sv
// Bench of the block
`timescale 1ns/10ps
module self_program_flash_control_tb_top;
  logic        clock = 1'b0, rstn = 1'b0, por_n = 1'b0;
  logic        avs_read, avs_write, avs_waitrequest, global_irq_flag, eeprom_write_busy;
  logic        program_ready_irq, cpu_halt, flash_op_busy, flash_op_erase;
  logic [4:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, q, cells = 32'h81300f01;
  logic [14:0] flash_rd_addr;
  logic [15:0] flash_rd_data, buffer_rd_data;
  logic [12:0] flash_op_page;
  logic [1:0]  buffer_rd_index;
  logic [7:0]  fuse_exp [4] = '{8'hf0, 8'hfe, 8'h7e, 8'hcf};
  int          mismatches, total_checks, cycles;

  always #5 clock = ~clock;

  self_program_flash_control #(.PAGE_WORDS(4), .RC_DIV(2), .PROG_TICKS(4))
    i_self_program_flash_control (.clock, .rstn, .por_n, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest,
    .global_irq_flag, .eeprom_write_busy, .program_ready_irq, .cpu_halt,
    .lock_programmed(cells[1:0]), .low_fuse_programmed(cells[15:8]),
    .high_fuse_programmed(cells[23:16]), .extended_fuse_programmed(cells[31:24]),
    .flash_rd_addr, .flash_rd_data, .flash_op_busy, .flash_op_erase, .flash_op_page,
    .buffer_rd_index, .buffer_rd_data);

  flash_array_model i_flash_array_model (.clock, .flash_rd_addr, .flash_rd_data,
    .flash_op_busy, .flash_op_erase, .flash_op_page, .buffer_rd_index, .buffer_rd_data);

  // ------
  // Bus and compare tasks
  // ------
  task automatic complete_run();
    if (mismatches == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // Held until the edge that sees waitrequest low
  task automatic bus(input logic rd, input logic [4:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= rd;
    avs_write <= !rd;
    do @(negedge clock); while (avs_waitrequest !== 1'b0);
    @(posedge clock);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clock);
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bus(1'b0, a, d);
  endtask

  task automatic rd_chk(input logic [4:0] a, input logic [31:0] e);
    bus(1'b1, a, 32'h0);
    chk(q, e);
  endtask

  task automatic rd_byte(input logic [31:0] p, input logic [7:0] e);
    wr(5'h04, p);
    rd_chk(5'h10, {24'h0, e});
  endtask

  task automatic bit_chk(ref logic s, input logic e);
    @(negedge clock);
    chk(32'(s), 32'(e));
    @(posedge clock);
  endtask

  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      complete_run();
    end
  end

  // ------
  // Main sequence
  // ------
  initial
  begin
    {avs_read, avs_write, global_irq_flag, eeprom_write_busy} = 4'h0;
    avs_address = 5'h00;
    avs_writedata = 32'h0;
    repeat (5) @(posedge clock);
    rstn <= 1'b1;
    por_n <= 1'b1;
    @(posedge clock);
    rd_chk(5'h00, 32'h0);
    rd_chk(5'h14, 32'h0);
    global_irq_flag <= 1'b1;
    wr(5'h00, 32'hff);
    rd_chk(5'h00, 32'h80);
    bit_chk(program_ready_irq, 1'b1);
    wr(5'h00, 32'h81);
    bit_chk(program_ready_irq, 1'b0);
    for (int w = 0; w < 4; w++)
    begin
      wr(5'h04, 32'h10 + 32'(2 * w));
      wr(5'h08, {16'h0, 8'hc0 + 8'(w), 8'h30 + 8'(w)});
      wr(5'h00, 32'h01);
      wr(5'h0c, 32'h0);
    end
    rd_chk(5'h00, 32'h0);
    wr(5'h04, 32'h10);
    wr(5'h00, 32'h05);
    wr(5'h0c, 32'h0);
    rd_chk(5'h00, 32'h0);
    for (int w = 0; w < 4; w++)
    begin
      rd_byte(32'h10 + 32'(2 * w), 8'h30 + 8'(w));
      rd_byte(32'h11 + 32'(2 * w), 8'hc0 + 8'(w));
    end
    // Erase across a system reset
    wr(5'h00, 32'h03);
    fork
      wr(5'h0c, 32'h0);
      begin
        repeat (3) @(posedge clock);
        rstn <= 1'b0;
        repeat (2) @(posedge clock);
        rstn <= 1'b1;
      end
    join
    rd_byte(32'h10, 8'hff);
    wr(5'h04, 32'h20);
    wr(5'h08, 32'h1234);
    wr(5'h00, 32'h01);
    wr(5'h0c, 32'h0);
    wr(5'h00, 32'h11);
    wr(5'h00, 32'h05);
    wr(5'h0c, 32'h0);
    rd_byte(32'h20, 8'hff);
    wr(5'h00, 32'h01);
    repeat (4) @(posedge clock);
    rd_chk(5'h00, 32'h0);
    wr(5'h00, 32'h05);
    repeat (4) @(posedge clock);
    wr(5'h0c, 32'h0);
    bit_chk(flash_op_busy, 1'b0);
    for (int p = 0; p < 4; p++)
    begin
      wr(5'h04, 32'(p));
      wr(5'h00, 32'h09);
      rd_chk(5'h10, {24'h0, fuse_exp[p]});
    end
    rd_chk(5'h00, 32'h0);
    eeprom_write_busy <= 1'b1;
    wr(5'h00, 32'h09);
    rd_chk(5'h00, 32'h0);
    eeprom_write_busy <= 1'b0;
    complete_run();
  end
endmodule
